// File: shared/pcam_params.svh
// Purpose: Offsets, field positions, reset values and counts for the counter array
// Assumes: 8-bit register port, byte offsets as printed
// Notes: Definitions only
`ifndef PCAM_PARAMS_SVH
`define PCAM_PARAMS_SVH
// Register offsets
`define PCAM_CTRL_ADDR 8'hD8
`define PCAM_MD_ADDR 8'hD9
`define PCAM_CPM0_ADDR 8'hDA
`define PCAM_CPM1_ADDR 8'hDB
`define PCAM_CPM2_ADDR 8'hDC
`define PCAM_CNTL_ADDR 8'hF9
`define PCAM_CNTH_ADDR 8'hFA
`define PCAM_CPL0_ADDR 8'hFB
`define PCAM_CPL1_ADDR 8'hE9
`define PCAM_CPL2_ADDR 8'hEB
`define PCAM_CPH0_ADDR 8'hFC
`define PCAM_CPH1_ADDR 8'hEA
`define PCAM_CPH2_ADDR 8'hEC
// Field positions
`define PCAM_MD_WDOG_EN 6
`define PCAM_MD_LOCK 5
`define PCAM_CTRL_OVF 7
`define PCAM_CTRL_RUN 6
// Reset values
`define PCAM_MD_RESET 8'h40
`define PCAM_CPM_RESET 8'h00
`define PCAM_READ_NONE 8'h00
// Timebase counts
`define PCAM_PRE_LAST 4'hB
`define PCAM_DIV4_LAST 2'h3
`define PCAM_EXT_LAST 3'h7
`define PCAM_CNT_MAX 16'hFFFF
`endif

// File: shared/pcam_pkg.sv
// Purpose: Types shared by the counter array files
// Assumes: Field order matches the register bit order, msb first
// Notes: Constants live in pcam_params.svh
package pcam_pkg;
  // Counter increment sources
  typedef enum logic [2:0] {
    PCAM_TB_DIV12 = 3'h0,
    PCAM_TB_DIV4 = 3'h1,
    PCAM_TB_T0OVF = 3'h2,
    PCAM_TB_CNTPIN = 3'h3,
    PCAM_TB_SYSCLK = 3'h4,
    PCAM_TB_EXT8 = 3'h5,
    PCAM_TB_RSVD6 = 3'h6,
    PCAM_TB_RSVD7 = 3'h7
  } pcam_tb_type;

  // Array mode register
  typedef struct packed {
    logic idle_suspend;
    logic watchdog_enable;
    logic watchdog_lock;
    logic unused;
    pcam_tb_type timebase_select;
    logic overflow_irq_enable;
  } pcam_md_type;

  // Per-module mode register
  typedef struct packed {
    logic wide_pwm_select;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_enable;
    logic toggle_enable;
    logic pulse_width_enable;
    logic module_flag_irq_enable;
  } pcam_cpm_type;
endpackage : pcam_pkg

// File: design/pcam_ccm.sv
// Purpose: One capture/compare module of the counter array
// Assumes: count_next is the value the counter takes when tick is high
// Notes: Software writes to the compare bytes win over a capture
`timescale 1ns/1ns
module pcam_ccm
  import pcam_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic arst_n,
  // Mode and timebase
  input pcam_cpm_type mode,
  input logic active,
  input logic tick,
  input logic [15:0] count,
  input logic [15:0] count_next,
  // Compare byte writes
  input logic wr_low,
  input logic wr_high,
  input logic [7:0] wdata,
  // Pins and results
  input logic cap_pin,
  output logic [15:0] cmp,
  output logic flag_set,
  output logic module_output_pin
);
  logic pin_s1, pin_s2, pin_s3;
  logic capture, match16, match8, ovf8, ovf16, pwm_on, freq_on;

  // Pin synchroniser, third stage only for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end else begin
      pin_s1 <= cap_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Event decode
  assign capture = active && ((mode.rising_capture_enable && pin_s2 && !pin_s3) // R12 R24
    || (mode.falling_capture_enable && !pin_s2 && pin_s3)); // R13
  assign match16 = mode.comparator_enable && tick && (count_next == cmp); // R11
  assign match8 = mode.comparator_enable && tick && (count_next[7:0] == cmp[7:0]);
  assign ovf8 = tick && (count_next[7:0] == 8'h00);
  assign ovf16 = tick && (count_next == 16'h0000);
  assign pwm_on = mode.pulse_width_enable && !mode.toggle_enable; // R16
  assign freq_on = mode.pulse_width_enable && mode.toggle_enable; // R17
  assign flag_set = capture || (mode.match_enable && match16); // R14 R21

  // Compare value: software, capture, 8-bit reload and frequency step
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp <= 16'h0000;
    end else if (wr_low) begin
      cmp[7:0] <= wdata;
    end else if (wr_high) begin
      cmp[15:8] <= wdata;
    end else if (capture) begin
      cmp <= count; // R24
    end else if (freq_on && match8) begin
      cmp[7:0] <= cmp[7:0] + cmp[15:8]; // R17
    end else if (pwm_on && !mode.wide_pwm_select && ovf8) begin
      cmp[7:0] <= cmp[15:8]; // R10
    end
  end

  // Output pin waveform
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      module_output_pin <= 1'b0;
    end else if (freq_on) begin
      if (match8) module_output_pin <= !module_output_pin; // R17
    end else if (pwm_on && mode.wide_pwm_select) begin
      if (match16) module_output_pin <= 1'b1; // R10
      else if (ovf16) module_output_pin <= 1'b0;
    end else if (pwm_on) begin
      if (match8) module_output_pin <= 1'b1; // R10
      else if (ovf8) module_output_pin <= 1'b0;
    end else if (mode.toggle_enable && match16) begin
      module_output_pin <= !module_output_pin; // R15
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_capture;
    capture && !wr_low && !wr_high |=> cmp == $past(count);
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost counter value"); // R24

  property p_toggle;
    match16 && mode.toggle_enable && !mode.pulse_width_enable
      |=> module_output_pin != $past(module_output_pin);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle match did not invert"); // R15

  property p_pwm16;
    ovf16 && !match16 && pwm_on && mode.wide_pwm_select |=> !module_output_pin;
  endproperty
  a_pwm16: assert property (p_pwm16) else $error("16-bit pwm not low at wrap"); // R10
endmodule : pcam_ccm

// File: design/pcam_array.sv
// Purpose: Mode, timebase and per-module control of the counter array
// Assumes: cpu_idle and timer0_overflow come from logic on clk
// Notes: Watchdog timeout arithmetic sits outside; module 2 goes quiet under it
`timescale 1ns/1ns
`include "pcam_params.svh"

// How it works
// (R01) Idle-suspend set halts the array while the processor idles.
// (R02) Watchdog enable hands module 2 to the watchdog; clearing disables it.
// (R03) Once locked, the watchdog cannot be disabled until reset.
// (R04) Bit 4 of array mode reads zero; writes ignored.
// (R05) Timebase select picks div12, div4, timer 0 overflow or system clock.
// (R06) Code 011 counts falling edges of the external count input.
// (R07) Code 101 counts the synchronised external clock divided by 8.
// (R08) Overflow interrupt enable gates the overflow flag onto the request.
// (R09) While watchdog enabled, other array mode bits keep their value.
// (R10) Wide select picks 16-bit or 8-bit pulse width modulation.
// (R11) Comparator enable turns on counter versus compare matching.
// (R12) Rising-capture enable captures on rising pin edges.
// (R13) Falling-capture enable captures on falling edges; both give either edge.
// (R14) Match enable makes a match set the module flag.
// (R15) Toggle enable inverts the output pin on each match.
// (R16) Pulse-width enable drives a modulated waveform on the pin.
// (R17) Toggle plus pulse-width gives frequency output mode.
// (R18) Module flag interrupt enable gates the module flag onto the request.
// (R19) Under watchdog, module 2 mode writes are ignored.
// (R20) Counter wrap from maximum to zero sets the overflow flag.
// (R21) Hardware only sets module flags; software clears them.
// (R22) Compare low byte write clears comparator enable.
// (R23) Compare high byte write sets comparator enable.
// (R24) A qualifying synchronised edge copies the counter into compare.
module pcam_array
  import pcam_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic arst_n,
  // Register port
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [7:0] reg_rdata,
  // System inputs on clk
  input logic cpu_idle,
  input logic timer0_overflow,
  // Pins from outside the clock domain
  input logic external_count_input,
  input logic ext_osc_clk,
  input logic [2:0] cap_pin,
  // Outputs
  output logic [2:0] module_output_pin,
  output logic irq,
  output logic watchdog_enable,
  output logic watchdog_lock
);
  pcam_md_type md;
  pcam_cpm_type cpm [3];
  pcam_cpm_type eff_mode [3];
  logic run, ovf_flag, active, tick, md_wr, cnt_wr;
  logic [2:0] cc_flag, flag_set, cpl_hit, cph_hit, cpm_hit;
  logic [15:0] count, count_next;
  logic [15:0] cmp [3];
  logic [7:0] snap, md_bits;
  logic [3:0] pre;
  logic [2:0] ext_div;
  logic cin_s1, cin_s2, cin_s3, ext_s1, ext_s2, ext_s3;

  // One-hot module select from an address and three offsets
  function automatic logic [2:0] f_hit(input logic [7:0] a, input logic [7:0] o0,
                                       input logic [7:0] o1, input logic [7:0] o2);
    f_hit = {a == o2, a == o1, a == o0};
  endfunction : f_hit

  // Address decode shared by writes and reads
  assign cpl_hit = f_hit(reg_addr, `PCAM_CPL0_ADDR, `PCAM_CPL1_ADDR, `PCAM_CPL2_ADDR);
  assign cph_hit = f_hit(reg_addr, `PCAM_CPH0_ADDR, `PCAM_CPH1_ADDR, `PCAM_CPH2_ADDR);
  assign cpm_hit = f_hit(reg_addr, `PCAM_CPM0_ADDR, `PCAM_CPM1_ADDR, `PCAM_CPM2_ADDR);
  assign md_wr = reg_wr && (reg_addr == `PCAM_MD_ADDR);
  // Counter byte writes are ignored while the watchdog owns the array
  assign cnt_wr = reg_wr && !md.watchdog_enable
    && (reg_addr == `PCAM_CNTL_ADDR || reg_addr == `PCAM_CNTH_ADDR);
  assign md_bits = md;

  // Array halts when suspended in idle
  assign active = run && !(md.idle_suspend && cpu_idle); // R01

  // Pin synchronisers; only second and third stages feed logic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cin_s1 <= 1'b1;
      cin_s2 <= 1'b1;
      cin_s3 <= 1'b1;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      cin_s1 <= external_count_input;
      cin_s2 <= cin_s1;
      cin_s3 <= cin_s2;
      ext_s1 <= ext_osc_clk;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Prescaler: one counter modulo 12 serves both divide-by-12 and divide-by-4
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre <= 4'h0;
    end else if (active) begin
      pre <= (pre == `PCAM_PRE_LAST) ? 4'h0 : pre + 4'h1;
    end
  end

  // External clock divider; the clock must stay below half of clk
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_div <= 3'h0;
    end else if (ext_s2 && !ext_s3) begin
      ext_div <= ext_div + 3'h1; // R07
    end
  end

  // Timebase select
  always_comb begin
    case (md.timebase_select)
      PCAM_TB_DIV12: tick = pre == `PCAM_PRE_LAST; // R05
      PCAM_TB_DIV4: tick = pre[1:0] == `PCAM_DIV4_LAST; // R05
      PCAM_TB_T0OVF: tick = timer0_overflow; // R05
      PCAM_TB_CNTPIN: tick = !cin_s2 && cin_s3; // R06
      PCAM_TB_SYSCLK: tick = 1'b1; // R05
      PCAM_TB_EXT8: tick = ext_s2 && !ext_s3 && (ext_div == `PCAM_EXT_LAST); // R07
      default: tick = 1'b0;
    endcase
    tick = tick && active; // R01
  end
  assign count_next = count + 16'h0001;

  // Counter with software byte writes taking priority
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 16'h0000;
    end else if (cnt_wr && reg_addr == `PCAM_CNTL_ADDR) begin
      count[7:0] <= reg_wdata;
    end else if (cnt_wr) begin
      count[15:8] <= reg_wdata;
    end else if (tick) begin
      count <= count_next;
    end
  end

  // High byte snapshot taken when the low byte is read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      snap <= 8'h00;
    end else if (reg_rd && reg_addr == `PCAM_CNTL_ADDR) begin
      snap <= count[15:8];
    end
  end

  // Array mode register; the lock can only be set, reset clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      md <= `PCAM_MD_RESET;
    end else if (md_wr && md.watchdog_enable) begin
      md.watchdog_enable <= md.watchdog_lock || reg_wdata[`PCAM_MD_WDOG_EN]; // R02 R03 R09
    end else if (md_wr) begin
      md <= reg_wdata;
      md.unused <= 1'b0; // R04
      md.watchdog_enable <= reg_wdata[`PCAM_MD_WDOG_EN] || reg_wdata[`PCAM_MD_LOCK]; // R02
    end
  end

  // Module mode registers with compare-byte side effects
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 3; i++) cpm[i] <= `PCAM_CPM_RESET;
    end else if (reg_wr) begin
      for (int i = 0; i < 3; i++) begin
        if (cpm_hit[i] && !(i == 2 && md.watchdog_enable)) begin
          cpm[i] <= reg_wdata; // R19
        end else if (cpl_hit[i]) begin
          cpm[i].comparator_enable <= 1'b0; // R22
        end else if (cph_hit[i]) begin
          cpm[i].comparator_enable <= 1'b1; // R23
        end
      end
    end
  end

  // Module 2 does nothing of its own while it serves as watchdog
  always_comb begin
    eff_mode[0] = cpm[0];
    eff_mode[1] = cpm[1];
    eff_mode[2] = md.watchdog_enable ? pcam_cpm_type'(`PCAM_CPM_RESET) : cpm[2]; // R02 R19
  end

  // Control and flags; a hardware set beats a clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 1'b0;
      ovf_flag <= 1'b0;
      cc_flag <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == `PCAM_CTRL_ADDR) begin
        run <= reg_wdata[`PCAM_CTRL_RUN];
        ovf_flag <= reg_wdata[`PCAM_CTRL_OVF] || (tick && count == `PCAM_CNT_MAX); // R20
        cc_flag <= reg_wdata[2:0] | flag_set; // R21
      end else begin
        ovf_flag <= ovf_flag || (tick && !cnt_wr && count == `PCAM_CNT_MAX); // R20
        cc_flag <= cc_flag | flag_set; // R21
      end
    end
  end

  // Capture/compare modules
  for (genvar g = 0; g < 3; g++) begin : g_ccm
    pcam_ccm u_ccm (
      .clk(clk),
      .arst_n(arst_n),
      .mode(eff_mode[g]),
      .active(active),
      .tick(tick && !cnt_wr),
      .count(count),
      .count_next(count_next),
      .wr_low(reg_wr && cpl_hit[g]),
      .wr_high(reg_wr && cph_hit[g]),
      .wdata(reg_wdata),
      .cap_pin(cap_pin[g]),
      .cmp(cmp[g]),
      .flag_set(flag_set[g]),
      .module_output_pin(module_output_pin[g])
    );
  end

  // Interrupt request, registered so the output comes from a flip-flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (ovf_flag && md.overflow_irq_enable) // R08
        || (cc_flag[0] && cpm[0].module_flag_irq_enable) // R18
        || (cc_flag[1] && cpm[1].module_flag_irq_enable)
        || (cc_flag[2] && cpm[2].module_flag_irq_enable);
    end
  end

  // Watchdog status for the reset logic outside
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      watchdog_enable <= 1'b1;
      watchdog_lock <= 1'b0;
    end else begin
      watchdog_enable <= md.watchdog_enable;
      watchdog_lock <= md.watchdog_lock;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `PCAM_READ_NONE;
    end else if (!reg_rd) begin
      reg_rdata <= `PCAM_READ_NONE;
    end else if (reg_addr == `PCAM_CTRL_ADDR) begin
      reg_rdata <= {ovf_flag, run, 3'h0, cc_flag};
    end else if (reg_addr == `PCAM_MD_ADDR) begin
      reg_rdata <= md_bits & 8'hEF; // R04
    end else if (|cpm_hit) begin
      reg_rdata <= cpm_hit[0] ? cpm[0] : (cpm_hit[1] ? cpm[1] : cpm[2]);
    end else if (reg_addr == `PCAM_CNTL_ADDR) begin
      reg_rdata <= count[7:0];
    end else if (reg_addr == `PCAM_CNTH_ADDR) begin
      reg_rdata <= snap;
    end else if (|cpl_hit) begin
      reg_rdata <= cpl_hit[0] ? cmp[0][7:0] : (cpl_hit[1] ? cmp[1][7:0] : cmp[2][7:0]);
    end else if (|cph_hit) begin
      reg_rdata <= cph_hit[0] ? cmp[0][15:8] : (cph_hit[1] ? cmp[1][15:8] : cmp[2][15:8]);
    end else begin
      reg_rdata <= `PCAM_READ_NONE;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_md_write;
    reg_wr && reg_addr == `PCAM_MD_ADDR;
  endsequence
  sequence s_md_read;
    reg_rd && reg_addr == `PCAM_MD_ADDR;
  endsequence

  property p_r09;
    md.watchdog_enable ##0 s_md_write |=> (md_bits & 8'hBF) == ($past(md_bits) & 8'hBF);
  endproperty
  a_r09: assert property (p_r09) else $error("mode bits changed under watchdog"); // R09

  property p_r03;
    md.watchdog_lock |=> md.watchdog_enable && md.watchdog_lock;
  endproperty
  a_r03: assert property (p_r03) else $error("locked watchdog was disabled"); // R03

  property p_r04;
    s_md_read |=> reg_rdata[4] == 1'b0;
  endproperty
  a_r04: assert property (p_r04) else $error("unused mode bit read as one"); // R04

  property p_r19;
    md.watchdog_enable && reg_wr && reg_addr == `PCAM_CPM2_ADDR |=> cpm[2] == $past(cpm[2]);
  endproperty
  a_r19: assert property (p_r19) else $error("module 2 mode written under watchdog"); // R19

  property p_r22;
    reg_wr && reg_addr == `PCAM_CPL0_ADDR |=> !cpm[0].comparator_enable;
  endproperty
  a_r22: assert property (p_r22) else $error("low byte write kept comparator on"); // R22

  property p_r23;
    reg_wr && reg_addr == `PCAM_CPH1_ADDR |=> cpm[1].comparator_enable;
  endproperty
  a_r23: assert property (p_r23) else $error("high byte write left comparator off"); // R23

  property p_r20;
    tick && !cnt_wr && count == `PCAM_CNT_MAX |=> ovf_flag && count == 16'h0000;
  endproperty
  a_r20: assert property (p_r20) else $error("wrap did not set overflow flag"); // R20

  property p_r01;
    md.idle_suspend && cpu_idle && !cnt_wr |=> $stable(count);
  endproperty
  a_r01: assert property (p_r01) else $error("counter ran in suspended idle"); // R01

  property p_r21;
    flag_set[1] |=> cc_flag[1] ##1 (cc_flag[1] || $past(reg_wr));
  endproperty
  a_r21: assert property (p_r21) else $error("module flag lost or self-cleared"); // R21

  property p_r08;
    ovf_flag && md.overflow_irq_enable |=> irq;
  endproperty
  a_r08: assert property (p_r08) else $error("overflow request not raised"); // R08
endmodule : pcam_array

// File: sim/pcam_array_test.sv
// Purpose: Self-checking bench for the counter array mode and module control
// Assumes: Read data stand in the cycle after the read strobe, else 0x00
// Notes: Rates and waveforms are checked within a small tolerance for prescaler phase
`timescale 1ns/1ns
`include "pcam_params.svh"
module pcam_array_test
  import pcam_pkg::*;
;
  localparam logic [7:0] a_ct = `PCAM_CTRL_ADDR;
  localparam logic [7:0] a_md = `PCAM_MD_ADDR;
  localparam logic [7:0] a_cl = `PCAM_CNTL_ADDR;
  localparam logic [7:0] a_ch = `PCAM_CNTH_ADDR;
  // Design ports
  logic clk, arst_n, reg_wr, reg_rd, cpu_idle, timer0_overflow;
  logic external_count_input, ext_osc_clk, irq, watchdog_enable, watchdog_lock;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, lo, hi;
  logic [2:0] cap_pin, module_output_pin;
  // Bench state
  int failures, compares, n_hi, n_tg;
  int cyc = 0;
  logic meas, pin_q;
  // Timebase table: mode byte, idle level, expected count over 241 cycles
  logic [7:0] tmd [10] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h88, 8'h08};
  logic [9:0] tidl = 10'h300;
  logic [15:0] tex [10] = '{16'h0014, 16'h003C, 16'h0028, 16'h0018, 16'h00F1, 16'h0005,
                            16'h0000, 16'h0000, 16'h0000, 16'h00F1};
  // Capture table: module 1 mode, flag after rise, flag after fall
  logic [7:0] cmd [3] = '{8'h20, 8'h10, 8'h30};
  logic [7:0] crs [3] = '{8'h02, 8'h00, 8'h02};
  logic [7:0] cfl [3] = '{8'h00, 8'h02, 8'h02};
  // Waveform table: mode, compare low/high, expected high time and toggles
  logic [7:0] pmd [3] = '{8'h42, 8'hC2, 8'h46};
  logic [7:0] pcl [3] = '{8'h80, 8'h80, 8'h00};
  logic [7:0] pch [3] = '{8'h80, 8'hFF, 8'h10};
  logic [15:0] phi [3] = '{16'h0100, 16'h0080, 16'h0104};
  logic [15:0] ptg [3] = '{16'h0004, 16'h0002, 16'h0020};

  pcam_array dut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle),
    .timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
    .ext_osc_clk(ext_osc_clk), .cap_pin(cap_pin), .module_output_pin(module_output_pin),
    .irq(irq), .watchdog_enable(watchdog_enable), .watchdog_lock(watchdog_lock)
  );

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Timer 0 pulse every 6, count input fall every 10, outside clock period 6
  always @(posedge clk) begin
    cyc <= cyc + 1;
    timer0_overflow <= (cyc % 6 == 5);
    if (cyc % 5 == 4) external_count_input <= ~external_count_input;
    if (cyc % 3 == 2) ext_osc_clk <= ~ext_osc_clk;
  end

  // Module 0 pin high time and toggles, counted only inside a window
  always @(posedge clk) begin
    pin_q <= module_output_pin[0];
    if (!meas) begin
      n_hi <= 0;
      n_tg <= 0;
    end else begin
      if (module_output_pin[0] === 1'b1) n_hi <= n_hi + 1;
      if (pin_q !== module_output_pin[0]) n_tg <= n_tg + 1;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rdr

  // Waits land 1 ns past the edge so registered outputs have settled
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  // Range compare; an unknown never passes
  task automatic chkn(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] tol);
    compares++;
    if (^got === 1'bx || got + tol < exp || got > exp + tol) begin
      failures++;
      $display("BAD at %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask : chkn

  task automatic test_done();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // Hang guard, well beyond the roughly 4500 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("BAD at %0t: run did not finish", $time);
    test_done();
  end

  initial begin
    failures = 0;
    compares = 0;
    meas = 1'b0;
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cpu_idle = 1'b0;
    timer0_overflow = 1'b0;
    external_count_input = 1'b1;
    ext_osc_clk = 1'b0;
    cap_pin = 3'h0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    // Reset state, locked-out mode writes, unmapped read
    cycles(1);
    chk8({6'h00, watchdog_lock, watchdog_enable}, 8'h01);
    rdr(a_md, rd);
    chk8(rd, 8'h40);
    rdr(8'h10, rd);
    chk8(rd, 8'h00);
    wr(a_md, 8'hDF);
    rdr(a_md, rd);
    chk8(rd, 8'h40);
    wr(8'hDC, 8'h4D);
    rdr(8'hDC, rd);
    chk8(rd, 8'h00);
    wr(a_md, 8'h00);
    cycles(2);
    chk8({7'h00, watchdog_enable}, 8'h00);
    wr(a_md, 8'h9F);
    rdr(a_md, rd);
    chk8(rd, 8'h8F);
    wr(a_md, 8'h00);
    wr(8'hDC, 8'h4D);
    rdr(8'hDC, rd);
    chk8(rd, 8'h4D);
    wr(8'hDC, 8'h00);
    $display("test watchdog done");
    // Every timebase code, and idle with and without suspension
    for (int i = 0; i < 10; i++) begin
      wr(a_ct, 8'h00);
      wr(a_cl, 8'h00);
      wr(a_ch, 8'h00);
      wr(a_md, tmd[i]);
      cpu_idle <= tidl[i];
      wr(a_ct, 8'h40);
      cycles(239);
      wr(a_ct, 8'h00);
      rdr(a_cl, lo);
      rdr(a_ch, hi);
      chkn({hi, lo}, tex[i], 16'h0003);
    end
    cpu_idle <= 1'b0;
    $display("test timebase done");
    // Wrap sets the overflow flag; request follows its enable
    wr(a_cl, 8'hF0);
    wr(a_ch, 8'hFF);
    wr(a_md, 8'h08);
    wr(a_ct, 8'h40);
    cycles(30);
    rdr(a_ct, rd);
    chk8(rd & 8'h80, 8'h80);
    chk8({7'h00, irq}, 8'h00);
    wr(a_md, 8'h09);
    cycles(3);
    chk8({7'h00, irq}, 8'h01);
    wr(a_ct, 8'h00);
    cycles(3);
    chk8({7'h00, irq}, 8'h00);
    wr(a_md, 8'h08);
    $display("test overflow done");
    // Compare byte writes steer the comparator; match sets flag and toggles pin
    wr(8'hDA, 8'h4D);
    wr(8'hFB, 8'h20);
    rdr(8'hDA, rd);
    chk8(rd, 8'h0D);
    wr(8'hFC, 8'h00);
    rdr(8'hDA, rd);
    chk8(rd, 8'h4D);
    wr(8'hEA, 8'h00);
    rdr(8'hDB, rd);
    chk8(rd, 8'h40);
    wr(a_cl, 8'h00);
    wr(a_ch, 8'h00);
    wr(a_ct, 8'h40);
    cycles(60);
    rdr(a_ct, rd);
    chk8(rd & 8'h81, 8'h01);
    chk8({7'h00, module_output_pin[0]}, 8'h01);
    chk8({7'h00, irq}, 8'h01);
    wr(8'hDA, 8'h4C);
    cycles(3);
    chk8({7'h00, irq}, 8'h00);
    $display("test match done");
    // Rising, falling and either-edge capture on module 1
    for (int j = 0; j < 3; j++) begin
      wr(8'hDB, cmd[j]);
      wr(a_ct, 8'h40);
      cap_pin[1] <= 1'b1;
      cycles(8);
      rdr(a_ct, rd);
      chk8(rd & 8'h02, crs[j]);
      wr(a_ct, 8'h40);
      cap_pin[1] <= 1'b0;
      cycles(8);
      rdr(a_ct, rd);
      chk8(rd & 8'h02, cfl[j]);
    end
    wr(8'hDB, 8'h00);
    // Modules 1 and 2 never ran a waveform mode, so their pins stay low
    chk8({6'h00, module_output_pin[2:1]}, 8'h00);
    $display("test capture done");
    // 8-bit, 16-bit and frequency output waveforms on module 0
    for (int k = 0; k < 3; k++) begin
      wr(a_ct, 8'h00);
      wr(8'hFB, pcl[k]);
      wr(8'hFC, pch[k]);
      wr(8'hDA, pmd[k]);
      wr(a_cl, 8'hF8);
      wr(a_ch, 8'hFD);
      wr(a_ct, 8'h40);
      cycles(16);
      meas <= 1'b1;
      cycles(520);
      chkn(16'(n_hi), phi[k], 16'h0008);
      chkn(16'(n_tg), ptg[k], 16'h0002);
      meas <= 1'b0;
    end
    wr(a_ct, 8'h00);
    wr(8'hDA, 8'h00);
    $display("test waveform done");
    // Lock holds the watchdog on until the next reset
    wr(a_md, 8'h60);
    cycles(2);
    chk8({6'h00, watchdog_lock, watchdog_enable}, 8'h03);
    wr(a_md, 8'h00);
    rdr(a_md, rd);
    chk8(rd, 8'h60);
    cycles(2);
    chk8({7'h00, watchdog_enable}, 8'h01);
    arst_n <= 1'b0;
    cycles(2);
    arst_n <= 1'b1;
    cycles(2);
    chk8({6'h00, watchdog_lock, watchdog_enable}, 8'h01);
    rdr(a_md, rd);
    chk8(rd, 8'h40);
    $display("test lock done");
    test_done();
  end
endmodule : pcam_array_test
